// file: verilog/rxlos_top.sv
// Receive loss detection, status registers and recovered data output format
//
// Overview of operation
// RULE_01 - Declare digital loss after 160 +/-32 zeros
// RULE_02 - Clear after four windows, ten ones each
// RULE_03 - Combined loss is analog OR digital loss
// RULE_04 - Loss drives output pin and status high
// RULE_05 - Status D2 reads analog loss state
// RULE_06 - Status D1 reads digital loss state
// RULE_07 - Detect control D2 disables analog detector
// RULE_08 - Detect control D1 disables digital detector
// RULE_09 - Both detectors disabled: never declare loss
// RULE_10 - Mute forces both rails low during loss
// RULE_11 - Hardware mode: mute follows mute pin
// RULE_12 - Host mode: output control D3 enables mute
// RULE_13 - Local loop-back declares loss; unmute first
// RULE_14 - Rails update on rising recovered clock
// RULE_15 - Positive pulse on positive rail, negative likewise
// RULE_16 - Recovered clocks run at the line rate
// RULE_17 - Output control D0 inverts recovered clock A
// RULE_18 - Clock B inverted by D1 or pin
// RULE_19 - Output control D4 selects single-rail binary data
// RULE_20 - Single-rail holds negative rail low
// RULE_21 - Synchronise analog loss before use
// RULE_22 - Counters step per bit; ones restart run
`timescale 1ns/1ps
`default_nettype none
module rxlos_top
  import rxlos_pkg::*;
#(
  parameter int ZERO_RUN = ZERO_RUN_NOM,
  parameter int LINE_RATE_KHZ = RATE_DS3_KHZ
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic line_clock,
  input wire logic line_pos,
  input wire logic line_neg,
  input wire logic line_binary,
  input wire logic analog_signal_loss,
  input wire logic lock_loss,
  input wire logic drive_monitor_fault,
  input wire logic local_loopback,
  input wire logic host_mode,
  input wire logic mute_on_loss_pin,
  input wire logic second_clock_invert_pin,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [REG_W-1:0] reg_wdata,
  output logic [REG_W-1:0] reg_rdata,
  output logic loss_of_signal_out,
  output logic positive_rail_out,
  output logic negative_rail_out,
  output logic recovered_clock_a,
  output logic recovered_clock_b
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  localparam int SYNC_W = 11;

  logic [SYNC_W-1:0] sync_s;
  logic clk_s;
  logic pos_s;
  logic neg_s;
  logic bin_s;
  logic analog_s;
  logic lol_s;
  logic fault_s;
  logic lpbk_s;
  logic host_s;
  logic mute_pin_s;
  logic invb_pin_s;

  // Data and clock share the same two-flop delay, so their alignment holds
  rxlos_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({line_clock, line_pos, line_neg, line_binary, analog_signal_loss,
               lock_loss, drive_monitor_fault, local_loopback, host_mode,
               mute_on_loss_pin, second_clock_invert_pin}),
    .sync_out(sync_s)
  ); // RULE_21

  assign {clk_s, pos_s, neg_s, bin_s, analog_s, lol_s, fault_s, lpbk_s, host_s,
          mute_pin_s, invb_pin_s} = sync_s;

  // ----------------------------------------------------------------
  // Command registers
  // ----------------------------------------------------------------
  logic [REG_W-1:0] detect_ctrl_q;
  logic [REG_W-1:0] output_ctrl_q;
  logic [REG_W-1:0] status_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      detect_ctrl_q <= DC_RESET;
      output_ctrl_q <= OC_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_DETECT_CTRL) begin
        detect_ctrl_q <= reg_wdata & DC_WRITE_MASK;
      end else if (reg_addr == ADDR_OUTPUT_CTRL) begin
        output_ctrl_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_addr == ADDR_LINE_STATUS) begin
      reg_rdata <= status_q;
    end else if (reg_addr == ADDR_DETECT_CTRL) begin
      reg_rdata <= detect_ctrl_q;
    end else if (reg_addr == ADDR_OUTPUT_CTRL) begin
      reg_rdata <= output_ctrl_q;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Effective controls
  // ----------------------------------------------------------------
  // Register controls only count in host mode; otherwise mute and clock B inversion follow pins and the rest stay off
  logic analog_dis;
  logic digital_dis;
  logic mute_en;
  logic inv_a;
  logic inv_b;
  logic clkb_dis;
  logic single_rail;

  assign analog_dis = host_s && detect_ctrl_q[DC_ANALOG_DIS]; // RULE_07
  assign digital_dis = host_s && detect_ctrl_q[DC_DIGITAL_DIS]; // RULE_08
  assign mute_en = host_s ? output_ctrl_q[OC_MUTE] : mute_pin_s; // RULE_11 RULE_12
  assign inv_a = host_s && output_ctrl_q[OC_CLKA_INV]; // RULE_17
  assign inv_b = host_s ? output_ctrl_q[OC_CLKB_INV] : invb_pin_s; // RULE_18
  assign clkb_dis = host_s && output_ctrl_q[OC_CLKB_DIS];
  assign single_rail = host_s && output_ctrl_q[OC_SINGLE_RAIL]; // RULE_19

  // ----------------------------------------------------------------
  // Recovered bit strobe
  // ----------------------------------------------------------------
  logic clk_d_q;
  logic bit_rise;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_d_q <= 1'b0;
    end else begin
      clk_d_q <= clk_s;
    end
  end

  assign bit_rise = clk_s && !clk_d_q;

  // ----------------------------------------------------------------
  // Loss detection
  // ----------------------------------------------------------------
  logic digital_loss;
  logic analog_eff;
  logic lpbk_loss;
  logic loss_d;
  logic loss_q;

  rxlos_digital_loss #(.ZERO_RUN(ZERO_RUN)) u_digital_loss (
    .clk(clk),
    .reset_n(reset_n),
    .bit_stb(bit_rise),
    .bit_one(pos_s || neg_s),
    .detect_dis(digital_dis),
    .loss(digital_loss)
  ); // RULE_22

  assign analog_eff = analog_s && !analog_dis; // RULE_07
  // Loop-back forces loss unless both detectors are disabled; hence muting must be off before entering it
  assign lpbk_loss = lpbk_s && !(analog_dis && digital_dis); // RULE_13 RULE_09
  assign loss_d = analog_eff || digital_loss || lpbk_loss; // RULE_03

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loss_q <= 1'b0;
      status_q <= '0;
    end else begin
      loss_q <= loss_d; // RULE_04
      status_q[LS_LOCK_LOSS] <= lol_s;
      status_q[LS_LOSS] <= loss_d; // RULE_04
      status_q[LS_ANALOG_LOSS] <= analog_eff; // RULE_05
      status_q[LS_DIGITAL_LOSS] <= digital_loss; // RULE_06
      status_q[LS_DRIVE_FAULT] <= fault_s;
    end
  end

  assign loss_of_signal_out = loss_q;

  // ----------------------------------------------------------------
  // Recovered clock outputs
  // ----------------------------------------------------------------
  // Clock A, and clock B unless disabled, follow the line clock, so they carry its rate unchanged
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      recovered_clock_a <= 1'b0;
      recovered_clock_b <= 1'b0;
    end else begin
      recovered_clock_a <= clk_s ^ inv_a; // RULE_16 RULE_17
      recovered_clock_b <= clkb_dis ? 1'b0 : (clk_s ^ inv_b); // RULE_16 RULE_18
    end
  end

  // ----------------------------------------------------------------
  // Data rails
  // ----------------------------------------------------------------
  logic mute_now;

  assign mute_now = mute_en && loss_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      positive_rail_out <= 1'b0;
      negative_rail_out <= 1'b0;
    end else if (mute_now) begin
      positive_rail_out <= 1'b0; // RULE_10
      negative_rail_out <= 1'b0; // RULE_10
    end else if (bit_rise) begin
      if (single_rail) begin
        positive_rail_out <= bin_s; // RULE_19
        negative_rail_out <= 1'b0; // RULE_20
      end else begin
        positive_rail_out <= pos_s; // RULE_14 RULE_15
        negative_rail_out <= neg_s; // RULE_14 RULE_15
      end
    end else if (single_rail) begin
      negative_rail_out <= 1'b0; // RULE_20
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_loss_is_or: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
    loss_of_signal_out == $past(analog_eff || digital_loss || lpbk_loss))
    else $error("loss output is not the OR of analog and digital loss");

  a_status_loss: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
    status_q[LS_LOSS] == loss_of_signal_out)
    else $error("loss status bit differs from loss pin");

  a_status_analog: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
    ##1 status_q[LS_ANALOG_LOSS] == $past(analog_s && !analog_dis))
    else $error("analog loss status wrong");

  a_status_digital: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
    ##1 status_q[LS_DIGITAL_LOSS] == $past(digital_loss))
    else $error("digital loss status wrong");

  a_both_disabled: assert property (@(posedge clk) disable iff (!reset_n) // RULE_09
    (analog_dis && digital_dis) [*2] |=> !loss_of_signal_out)
    else $error("loss declared with both detectors disabled");

  a_mute_rails: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
    mute_now |=> !positive_rail_out && !negative_rail_out)
    else $error("rails not muted during loss");

  a_rail_on_rise: assert property (@(posedge clk) disable iff (!reset_n) // RULE_14
    ($changed(positive_rail_out) && !$past(mute_now)) |-> $past(bit_rise))
    else $error("positive rail changed away from clock rise");

  a_dual_rail_map: assert property (@(posedge clk) disable iff (!reset_n) // RULE_15
    (bit_rise && !mute_now && !single_rail) |=>
      positive_rail_out == $past(pos_s) && negative_rail_out == $past(neg_s))
    else $error("dual-rail pulses not mapped to their rails");

  a_single_neg_low: assert property (@(posedge clk) disable iff (!reset_n) // RULE_20
    single_rail |=> !negative_rail_out)
    else $error("negative rail not held low in single-rail format");

  a_clock_a_inv: assert property (@(posedge clk) disable iff (!reset_n) // RULE_17
    recovered_clock_a == ($past(clk_s) ^ $past(inv_a)))
    else $error("recovered clock A polarity wrong");

  a_clock_a_edge: assert property (@(posedge clk) disable iff (!reset_n) // RULE_16
    (bit_rise && !inv_a) [*1] ##1 !inv_a |-> recovered_clock_a && !$past(recovered_clock_a, 1) ||
      $past(inv_a))
    else $error("recovered clock A does not follow line clock");

  a_clock_b_follow: assert property (@(posedge clk) disable iff (!reset_n) // RULE_18
    recovered_clock_b == (!$past(clkb_dis) && ($past(clk_s) ^ $past(inv_b))))
    else $error("recovered clock B polarity wrong");

  a_single_rail_data: assert property (@(posedge clk) disable iff (!reset_n) // RULE_19
    (bit_rise && !mute_now && single_rail) |=> positive_rail_out == $past(bin_s))
    else $error("single-rail data not on positive rail");

  a_pin_mute: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
    (!host_s && mute_pin_s && loss_of_signal_out) |=> !positive_rail_out && !negative_rail_out)
    else $error("rails not muted by mute pin in hardware mode");

  a_loopback_loss: assert property (@(posedge clk) disable iff (!reset_n) // RULE_13
    (lpbk_s && !(analog_dis && digital_dis)) |=> loss_of_signal_out)
    else $error("loss not declared in local loop-back");

endmodule
`default_nettype wire

// file: inc/rxlos_pkg.sv
// Shared constants and types for the receive loss detect and output format block
package rxlos_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int REG_W = 5;
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_DETECT_CTRL = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_CTRL = 3'h3;

  // line_status fields
  localparam int LS_DRIVE_FAULT = 0;
  localparam int LS_DIGITAL_LOSS = 1;
  localparam int LS_ANALOG_LOSS = 2;
  localparam int LS_LOSS = 3;
  localparam int LS_LOCK_LOSS = 4;

  // receive_detect_control fields
  localparam int DC_EQ_BYPASS = 0;
  localparam int DC_DIGITAL_DIS = 1;
  localparam int DC_ANALOG_DIS = 2;
  localparam int DC_CODEC_DIS = 3;
  localparam logic [REG_W-1:0] DC_WRITE_MASK = 5'h0F;
  localparam logic [REG_W-1:0] DC_RESET = 5'h00;

  // receive_output_control fields
  localparam int OC_CLKA_INV = 0;
  localparam int OC_CLKB_INV = 1;
  localparam int OC_CLKB_DIS = 2;
  localparam int OC_MUTE = 3;
  localparam int OC_SINGLE_RAIL = 4;
  localparam logic [REG_W-1:0] OC_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Digital loss criteria, in recovered bit periods except WIN_GOOD, which counts windows
  // ----------------------------------------------------------------
  localparam int ZERO_RUN_NOM = 160;
  localparam int ZERO_RUN_TOL = 32;
  localparam int WIN_BITS = 32;
  localparam int WIN_MIN_ONES = 10;
  localparam int WIN_GOOD = 4;

  // Nominal line rates in kHz
  localparam int RATE_E3_KHZ = 34368;
  localparam int RATE_DS3_KHZ = 44736;
  localparam int RATE_STS1_KHZ = 51840;

  typedef enum logic {
    DL_CLEAR,
    DL_LOST
  } rxlos_dl_state_e;

endpackage

// file: verilog/rxlos_sync.sv
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module rxlos_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// file: verilog/rxlos_digital_signal_loss.sv
// Digital loss detector: zero-run declare, ones-density clear
`timescale 1ns/1ps
`default_nettype none
module rxlos_digital_loss
  import rxlos_pkg::*;
#(
  parameter int ZERO_RUN = ZERO_RUN_NOM
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bit_stb,
  input wire logic bit_one,
  input wire logic detect_dis,
  output logic loss
);

  localparam logic [7:0] ZERO_LAST = 8'(ZERO_RUN - 1);
  localparam logic [4:0] WIN_LAST = 5'(WIN_BITS - 1);
  localparam logic [5:0] ONES_MIN = 6'(WIN_MIN_ONES);
  localparam logic [2:0] GOOD_LAST = 3'(WIN_GOOD - 1);

  rxlos_dl_state_e state_q;
  logic [7:0] zero_q;
  logic [4:0] win_q;
  logic [5:0] ones_q;
  logic [2:0] good_q;
  logic [5:0] ones_d;
  logic win_end;
  logic win_good;
  logic declare;

  assign ones_d = ones_q + {5'h00, bit_one};
  assign win_end = bit_stb && (win_q == WIN_LAST);
  assign win_good = ones_d >= ONES_MIN;
  assign declare = bit_stb && !bit_one && (zero_q == ZERO_LAST);
  assign loss = (state_q == DL_LOST);

  // ----------------------------------------------------------------
  // Zero run, one step per recovered bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_q <= 8'h00;
    end else if (detect_dis || (bit_stb && bit_one)) begin
      zero_q <= 8'h00; // RULE_22
    end else if (bit_stb && zero_q != ZERO_LAST) begin
      zero_q <= zero_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Density windows
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_q <= 5'h00;
      ones_q <= 6'h00;
      good_q <= 3'h0;
    end else if (detect_dis) begin
      win_q <= 5'h00;
      ones_q <= 6'h00;
      good_q <= 3'h0;
    end else if (bit_stb) begin
      win_q <= win_q + 5'h01;
      ones_q <= win_end ? 6'h00 : ones_d;
      if (declare) begin
        good_q <= 3'h0;
      end else if (win_end) begin
        good_q <= (win_good && good_q != GOOD_LAST) ? good_q + 3'h1 : 3'h0; // RULE_02
      end
    end
  end

  // ----------------------------------------------------------------
  // Declare and clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= DL_CLEAR;
    end else if (detect_dis) begin
      state_q <= DL_CLEAR; // RULE_08
    end else begin
      case (state_q)
        DL_CLEAR: begin
          if (declare) begin
            state_q <= DL_LOST; // RULE_01
          end
        end
        DL_LOST: begin
          if (win_end && win_good && good_q == GOOD_LAST) begin
            state_q <= DL_CLEAR; // RULE_02
          end
        end
        default: begin
          state_q <= DL_CLEAR;
        end
      endcase
    end
  end

  a_zero_run_declare: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
    (declare && !detect_dis) |=> loss)
    else $error("digital loss not declared after zero run");

  a_one_restarts_run: assert property (@(posedge clk) disable iff (!reset_n) // RULE_22
    (bit_stb && bit_one) |=> zero_q == 8'h00)
    else $error("zero run not restarted by a one");

  a_clear_after_good: assert property (@(posedge clk) disable iff (!reset_n) // RULE_02
    $fell(loss) |-> $past(detect_dis) || ($past(good_q) == GOOD_LAST && $past(win_end)))
    else $error("digital loss cleared without four good windows");

  a_disable_holds: assert property (@(posedge clk) disable iff (!reset_n) // RULE_08
    detect_dis |=> !loss)
    else $error("digital loss shown while detector disabled");

endmodule
`default_nettype wire

// file: tb/rxlos_framer_model.sv
// Receiving terminal model: takes the rails at each rise of recovered clock A
`timescale 1ns/1ps
`default_nettype none
module rxlos_framer_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic rclk,
  input wire logic pos,
  input wire logic neg,
  output logic stb,
  output logic [1:0] rails
);
  logic rclk_q;

  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  // Rails and clock move together, so the rise is seen one clk later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rclk_q <= 1'b0;
      stb <= 1'b0;
      rails <= 2'h0;
    end else begin
      rclk_q <= rclk;
      stb <= enable && rclk && !rclk_q;
      if (rclk && !rclk_q) begin
        rails <= {pos, neg};
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/rxlos_top_tb.sv
// Self-checking bench for the receive loss detect and output format block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module rxlos_top_tb
  import rxlos_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic line_clock = 1'b0;
  logic line_pos = 1'b0;
  logic line_neg = 1'b0;
  logic line_binary = 1'b0;
  logic analog_signal_loss = 1'b0;
  logic lock_loss = 1'b0;
  logic drive_monitor_fault = 1'b0;
  logic local_loopback = 1'b0;
  logic host_mode = 1'b1;
  logic mute_on_loss_pin = 1'b0;
  logic second_clock_invert_pin = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic reg_wr = 1'b0;
  logic [REG_W-1:0] reg_wdata = 5'h00;
  logic [REG_W-1:0] reg_rdata;
  logic loss_of_signal_out, positive_rail_out, negative_rail_out;
  logic recovered_clock_a, recovered_clock_b;
  logic arm = 1'b0;
  logic got_stb;
  logic [1:0] got_rails;
  logic single = 1'b0;
  logic mute_now = 1'b0;
  logic [2:0] exp_q[$];
  logic [2:0] note;
  int errors = 0;
  int checked = 0;
  int seed = 71245;
  logic [1:0] r;

  rxlos_top #(.ZERO_RUN(8)) i_rxlos_top (.clk(clk), .reset_n(reset_n),
    .line_clock(line_clock), .line_pos(line_pos), .line_neg(line_neg),
    .line_binary(line_binary), .analog_signal_loss(analog_signal_loss),
    .lock_loss(lock_loss), .drive_monitor_fault(drive_monitor_fault),
    .local_loopback(local_loopback), .host_mode(host_mode),
    .mute_on_loss_pin(mute_on_loss_pin), .second_clock_invert_pin(second_clock_invert_pin),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .loss_of_signal_out(loss_of_signal_out), .positive_rail_out(positive_rail_out),
    .negative_rail_out(negative_rail_out), .recovered_clock_a(recovered_clock_a),
    .recovered_clock_b(recovered_clock_b));

  rxlos_framer_model i_rxlos_framer_model (.clk(clk), .reset_n(reset_n), .enable(arm),
    .rclk(recovered_clock_a), .pos(positive_rail_out), .neg(negative_rail_out),
    .stb(got_stb), .rails(got_rails));

  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
    reg_addr = a;
    tick(2);
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  // One bit period of 160 ns; data flips while the clock is low
  task automatic send(input logic p, input logic n, input logic b, input logic care);
    exp_q.push_back({care, mute_now ? 2'b00 : (single ? {b, 1'b0} : {p, n})});
    line_pos = p;
    line_neg = n;
    line_binary = b;
    line_clock = 1'b1;
    tick(10);
    line_clock = 1'b0;
    line_pos = ~p;
    line_neg = ~n;
    line_binary = ~b;
    tick(10);
  endtask

  task automatic burst(input int cnt, input logic p, input logic care);
    for (int i = 0; i < cnt; i++) begin
      send(p, 1'b0, p, care);
    end
  endtask

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset_n && got_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("wrong value rails expected none seen %0h", got_rails);
      end else begin
        note = exp_q.pop_front();
        if (note[2]) `CHK("rails", note[1:0], got_rails)
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    rd(ADDR_LINE_STATUS, 5'h00);
    rd(ADDR_DETECT_CTRL, DC_RESET);
    rd(ADDR_OUTPUT_CTRL, OC_RESET);
    wr(ADDR_DETECT_CTRL, 5'h1F);
    rd(ADDR_DETECT_CTRL, 5'h0F);
    wr(ADDR_LINE_STATUS, 5'h1F);
    rd(ADDR_LINE_STATUS, 5'h00);
    wr(3'h1, 5'h1F);
    rd(3'h1, 5'h00);
    wr(ADDR_DETECT_CTRL, 5'h00);
    wr(ADDR_OUTPUT_CTRL, 5'h03);
    tick(3);
    `CHK("clock_a", 1'b1, recovered_clock_a)
    `CHK("clock_b", 1'b1, recovered_clock_b)
    wr(ADDR_OUTPUT_CTRL, 5'h1F);
    rd(ADDR_OUTPUT_CTRL, 5'h1F);
    wr(ADDR_OUTPUT_CTRL, 5'h00);
    tick(4);
    arm = 1'b1;
    for (int i = 0; i < 24; i++) begin
      r = 2'($random(seed));
      send(r[1], r[1] ? 1'b0 : r[0], r[0], 1'b1);
    end
    wr(ADDR_OUTPUT_CTRL, 5'h10);
    single = 1'b1;
    burst(1, 1'b1, 1'b0);
    for (int i = 0; i < 16; i++) begin
      send(1'b1, 1'b0, 1'($random(seed)), 1'b1);
    end
    wr(ADDR_OUTPUT_CTRL, 5'h08);
    single = 1'b0;
    burst(7, 1'b0, 1'b1);
    send(1'b1, 1'b0, 1'b1, 1'b1);
    rd(ADDR_LINE_STATUS, 5'h00);
    burst(8, 1'b0, 1'b1);
    `CHK("loss", 1'b1, loss_of_signal_out)
    rd(ADDR_LINE_STATUS, 5'h0A);
    mute_now = 1'b1;
    burst(96, 1'b1, 1'b1);
    rd(ADDR_LINE_STATUS, 5'h0A);
    burst(32, 1'b1, 1'b0);
    mute_now = 1'b0;
    burst(4, 1'b1, 1'b1);
    rd(ADDR_LINE_STATUS, 5'h00);
    analog_signal_loss = 1'b1;
    lock_loss = 1'b1;
    drive_monitor_fault = 1'b1;
    tick(6);
    `CHK("loss", 1'b1, loss_of_signal_out)
    rd(ADDR_LINE_STATUS, 5'h1D);
    wr(ADDR_DETECT_CTRL, 5'h04);
    rd(ADDR_LINE_STATUS, 5'h11);
    `CHK("loss", 1'b0, loss_of_signal_out)
    lock_loss = 1'b0;
    drive_monitor_fault = 1'b0;
    wr(ADDR_OUTPUT_CTRL, 5'h00);
    wr(ADDR_DETECT_CTRL, 5'h06);
    local_loopback = 1'b1;
    tick(6);
    `CHK("loss", 1'b0, loss_of_signal_out)
    analog_signal_loss = 1'b0;
    wr(ADDR_DETECT_CTRL, 5'h00);
    tick(6);
    `CHK("loss", 1'b1, loss_of_signal_out)
    local_loopback = 1'b0;
    wr(ADDR_DETECT_CTRL, 5'h02);
    tick(6);
    burst(10, 1'b0, 1'b1);
    send(1'b1, 1'b0, 1'b1, 1'b1);
    rd(ADDR_LINE_STATUS, 5'h00);
    wr(ADDR_DETECT_CTRL, 5'h00);
    host_mode = 1'b0;
    mute_on_loss_pin = 1'b1;
    analog_signal_loss = 1'b1;
    tick(6);
    mute_now = 1'b1;
    burst(3, 1'b1, 1'b1);
    mute_on_loss_pin = 1'b0;
    analog_signal_loss = 1'b0;
    tick(6);
    mute_now = 1'b0;
    burst(3, 1'b1, 1'b1);
    second_clock_invert_pin = 1'b1;
    tick(6);
    `CHK("clock_b", 1'b1, recovered_clock_b)
    host_mode = 1'b1;
    second_clock_invert_pin = 1'b0;
    for (int i = 0; i < 100 && exp_q.size() > 0; i++) begin
      tick(1);
    end
    if (exp_q.size() > 0) begin
      errors++;
    end
    give_verdict();
  end
endmodule
`default_nettype wire
